// ==== verilog/apm_aux_pin_mux.v ====
// Configurable auxiliary pin multiplexer with APB configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "apm_consts.vh"

module apm_aux_pin_mux #(
   parameter [`APM_LED_CNT_W-1:0] LED_PULSE_CYC = `APM_LED_PULSE_CYC
) (
   // Clock and reset
   input  wire                    clk_i,
   input  wire                    nrst_i,
   // APB slave
   input  wire                    psel_i,
   input  wire                    penable_i,
   input  wire                    pwrite_i,
   input  wire [`APM_ADDR_W-1:0]  paddr_i,
   input  wire [31:0]             pwdata_i,
   input  wire [3:0]              pstrb_i,
   output wire [31:0]             prdata_o,
   output wire                    pready_o,
   output wire                    pslverr_o,
   // USB engine state and activity
   input  wire                    usb_configured_i,
   input  wire                    usb_suspend_i,
   input  wire                    usb_tx_act_i,
   input  wire                    usb_rx_act_i,
   // UART transmitter character framing
   input  wire                    uart_tx_start_i,
   input  wire                    uart_tx_done_i,
   // Clock generator outputs
   input  wire                    clock_out_48mhz_i,
   input  wire                    clock_out_24mhz_i,
   input  wire                    clock_out_12mhz_i,
   input  wire                    clock_out_6mhz_i,
   // Bit-bang engine strobes
   input  wire                    pin_write_strobe_n_i,
   input  wire                    pin_read_strobe_n_i,
   // Auxiliary pins, two-way
   input  wire [`APM_NPINS-1:0]   aux_pin_i,
   output wire [`APM_NPINS-1:0]   aux_pin_o,
   output wire [`APM_NPINS-1:0]   aux_pin_oe_o,
   // Weak pull-down request for the interface pins
   output wire                    aux_pulldown_o
);

   localparam SEL_W = `APM_NPINS * `APM_FUNC_W; // Width of all selectors
   // One bit per pin, so each generate slice picks exactly its own flag
   localparam [`APM_NPINS-1:0] LOW4_MASK = `APM_LOW4_MASK;

   // Configuration registers
   reg [SEL_W-1:0]        func_sel_reg;   // Per-pin function selectors
   reg [SEL_W-1:0]        func_sel_next;
   reg                    pulldown_reg;   // Suspend pull-down option
   reg                    pulldown_next;
   reg [3:0]              gpio_out_reg;   // GPIO output levels, pins 0..3
   reg [3:0]              gpio_out_next;
   reg [3:0]              gpio_oe_reg;    // GPIO drive enables, pins 0..3
   reg [3:0]              gpio_oe_next;

   // Bus answer
   reg [31:0]             prdata_reg;     // Read data, latched in setup
   reg [31:0]             prdata_next;
   reg                    unmapped_reg;   // Address decoded as unmapped
   reg                    unmapped_next;

   // Function sources
   reg                    rs485_en_reg;   // Character in flight on the UART
   wire                   power_en_n;     // Active-low power enable
   wire                   suspend_n;      // Active-low suspend indicator
   wire                   tx_led_n;       // Stretched transmit activity
   wire                   rx_led_n;       // Stretched receive activity
   wire                   any_led_n;      // Stretched combined activity

   // Pin drive
   reg [`APM_NPINS-1:0]   pin_out_reg;    // Registered pin levels
   reg [`APM_NPINS-1:0]   pin_oe_reg;     // Registered pin enables
   wire [`APM_NPINS-1:0]  pin_out_next;
   wire [`APM_NPINS-1:0]  pin_oe_next;

   // Write mask from byte strobes
   wire [31:0]            wmask;
   wire                   setup_ph;       // APB setup cycle
   wire                   wr_en;          // Write taking effect this edge

   assign wmask    = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
   assign setup_ph = psel_i & ~penable_i;
   assign wr_en    = psel_i & penable_i & pwrite_i;

   // Zero wait states: the answer is ready in the first access cycle
   assign pready_o  = psel_i & penable_i;
   assign pslverr_o = psel_i & penable_i & unmapped_reg;
   assign prdata_o  = prdata_reg;

   // Register writes honour byte strobes; status is read-only
   always @* begin
      func_sel_next = func_sel_reg;
      pulldown_next = pulldown_reg;
      gpio_out_next = gpio_out_reg;
      gpio_oe_next  = gpio_oe_reg;
      if (wr_en) begin
         case (paddr_i)
            `APM_OFS_FUNC_SEL: begin
               // Selector is the held configuration for every pin
               func_sel_next = (func_sel_reg & ~wmask[SEL_W-1:0]) | (pwdata_i[SEL_W-1:0] & wmask[SEL_W-1:0]);
            end
            `APM_OFS_CTRL: begin
               if (pstrb_i[0]) begin
                  pulldown_next = pwdata_i[`APM_CTRL_PULLDOWN];
               end
            end
            `APM_OFS_GPIO: begin
               // Each of the four GPIO pins has its own level and enable
               if (pstrb_i[0]) begin
                  gpio_out_next = pwdata_i[3:0];
                  gpio_oe_next  = pwdata_i[7:4];
               end
            end
            default: begin
               // Status and unmapped addresses store nothing
               func_sel_next = func_sel_reg;
            end
         endcase
      end
   end

   // Read mux, evaluated in the setup cycle so data comes from a flop
   always @* begin
      prdata_next   = prdata_reg;
      unmapped_next = unmapped_reg;
      if (setup_ph) begin
         prdata_next   = 32'h0000_0000;
         unmapped_next = 1'b0;
         case (paddr_i)
            `APM_OFS_FUNC_SEL: begin
               prdata_next[SEL_W-1:0] = func_sel_reg;
            end
            `APM_OFS_CTRL: begin
               prdata_next[`APM_CTRL_PULLDOWN] = pulldown_reg;
            end
            `APM_OFS_GPIO: begin
               prdata_next[7:0] = {gpio_oe_reg, gpio_out_reg};
            end
            `APM_OFS_STATUS: begin
               // Live pin levels, driven levels and engine state
               prdata_next[4:0]                = aux_pin_i;
               prdata_next[12:8]               = pin_out_reg;
               prdata_next[`APM_ST_CONFIGURED] = usb_configured_i;
               prdata_next[`APM_ST_SUSPEND]    = usb_suspend_i;
               prdata_next[`APM_ST_RS485]      = rs485_en_reg;
            end
            default: begin
               // Unmapped reads return zero and flag an error
               unmapped_next = 1'b1;
            end
         endcase
      end
   end

   // Configuration and bus flops; reset loads factory defaults
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         func_sel_reg <= `APM_FUNC_SEL_RST;
         pulldown_reg <= `APM_CTRL_RST;
         gpio_out_reg <= `APM_GPIO_OUT_RST;
         gpio_oe_reg  <= `APM_GPIO_OE_RST;
         prdata_reg   <= 32'h0000_0000;
         unmapped_reg <= 1'b0;
      end else begin
         func_sel_reg <= func_sel_next;
         pulldown_reg <= pulldown_next;
         gpio_out_reg <= gpio_out_next;
         gpio_oe_reg  <= gpio_oe_next;
         prdata_reg   <= prdata_next;
         unmapped_reg <= unmapped_next;
      end
   end

   // RS485 enable: set at start bit, cleared after last stop bit.
   // A start in the same cycle as a done wins, so back-to-back
   // characters keep the transceiver enabled without a glitch.
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rs485_en_reg <= 1'b0;
      end else if (uart_tx_start_i) begin
         rs485_en_reg <= 1'b1;
      end else if (uart_tx_done_i) begin
         rs485_en_reg <= 1'b0;
      end
   end

   // Power enable is low only while configured and not suspended
   assign power_en_n = ~(usb_configured_i & ~usb_suspend_i);
   // Suspend indicator follows the suspend state directly
   assign suspend_n  = ~usb_suspend_i;
   // Pull-down is requested only in suspend and only if enabled;
   // software pairs it with the power switch use
   assign aux_pulldown_o = pulldown_reg & usb_suspend_i;

   // Activity stretchers: short engine pulses would be invisible on an LED
   apm_led_stretch #(
      .PULSE_CYC (LED_PULSE_CYC)
   ) u_tx_led (
      .clk_i     (clk_i),
      .nrst_i    (nrst_i),
      .act_i     (usb_tx_act_i),
      .led_n_o   (tx_led_n)
   );

   apm_led_stretch #(
      .PULSE_CYC (LED_PULSE_CYC)
   ) u_rx_led (
      .clk_i     (clk_i),
      .nrst_i    (nrst_i),
      .act_i     (usb_rx_act_i),
      .led_n_o   (rx_led_n)
   );

   apm_led_stretch #(
      .PULSE_CYC (LED_PULSE_CYC)
   ) u_any_led (
      .clk_i     (clk_i),
      .nrst_i    (nrst_i),
      .act_i     (usb_tx_act_i | usb_rx_act_i),
      .led_n_o   (any_led_n)
   );

   // Per-pin function mux
   genvar gi;
   generate
      for (gi = 0; gi < `APM_NPINS; gi = gi + 1) begin : g_pin
         wire [`APM_FUNC_W-1:0] sel;      // This pin's selector
         wire                   low4;     // Pin is one of the first four
         wire [`APM_NPINS-1:0]  gpo_ext;  // GPIO levels padded to five pins
         wire [`APM_NPINS-1:0]  gpe_ext;  // GPIO enables padded to five pins
         reg                    out_sel;
         reg                    oe_sel;

         assign sel     = func_sel_reg[gi*`APM_FUNC_W +: `APM_FUNC_W];
         assign low4    = LOW4_MASK[gi];
         assign gpo_ext = {1'b0, gpio_out_reg};
         assign gpe_ext = {1'b0, gpio_oe_reg};

         // Unsupported codes, and restricted codes on pin 4, release the pin
         always @* begin
            out_sel = 1'b1;
            oe_sel  = 1'b1;
            case (sel)
               `APM_FN_RS485:     out_sel = rs485_en_reg;
               `APM_FN_PWR_EN:    out_sel = power_en_n;
               `APM_FN_TX_LED:    out_sel = tx_led_n;
               `APM_FN_RX_LED:    out_sel = rx_led_n;
               `APM_FN_ANY_LED:   out_sel = any_led_n;
               `APM_FN_SUSPEND:   out_sel = suspend_n;
               `APM_FN_CLOCK_OUT_48MHZ:     out_sel = clock_out_48mhz_i;
               `APM_FN_CLOCK_OUT_24MHZ:     out_sel = clock_out_24mhz_i;
               `APM_FN_CLOCK_OUT_12MHZ:     out_sel = clock_out_12mhz_i;
               `APM_FN_CLOCK_OUT_6MHZ:      out_sel = clock_out_6mhz_i;
               `APM_FN_GPIO: begin
                  // GPIO drives only when its own enable is set
                  out_sel = gpo_ext[gi];
                  oe_sel  = low4 & gpe_ext[gi];
               end
               `APM_FN_WR_STROBE: begin
                  out_sel = pin_write_strobe_n_i;
                  oe_sel  = low4;
               end
               `APM_FN_RD_STROBE: begin
                  out_sel = pin_read_strobe_n_i;
                  oe_sel  = low4;
               end
               default: begin
                  out_sel = 1'b1;
                  oe_sel  = 1'b0;
               end
            endcase
         end

         assign pin_out_next[gi] = out_sel;
         assign pin_oe_next[gi]  = oe_sel;
      end
   endgenerate

   // Pin flops; clocks pass through a 4 ns flop, so they carry
   // up to one cycle of jitter, acceptable for board logic only
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pin_out_reg <= {`APM_NPINS{1'b1}};
         pin_oe_reg  <= {`APM_NPINS{1'b0}};
      end else begin
         pin_out_reg <= pin_out_next;
         pin_oe_reg  <= pin_oe_next;
      end
   end

   assign aux_pin_o    = pin_out_reg;
   assign aux_pin_oe_o = pin_oe_reg;

endmodule // apm_aux_pin_mux
`default_nettype wire

// ==== verilog/apm_consts.vh ====
// Constants for the configurable auxiliary pin multiplexer
`ifndef APM_CONSTS_VH
`define APM_CONSTS_VH

// APB register byte offsets
`define APM_ADDR_W          12
`define APM_OFS_FUNC_SEL    12'h000
`define APM_OFS_CTRL        12'h004
`define APM_OFS_GPIO        12'h008
`define APM_OFS_STATUS      12'h00c

// Number of pins and width of one function selector
`define APM_NPINS           5
`define APM_FUNC_W          4
// Pins that may take general-purpose and strobe functions (first four)
`define APM_LOW4_MASK       5'h0f

// Function codes of one selector field
`define APM_FN_RS485        4'h0
`define APM_FN_PWR_EN       4'h1
`define APM_FN_TX_LED       4'h2
`define APM_FN_RX_LED       4'h3
`define APM_FN_ANY_LED      4'h4
`define APM_FN_SUSPEND      4'h5
`define APM_FN_CLOCK_OUT_48MHZ        4'h6
`define APM_FN_CLOCK_OUT_24MHZ        4'h7
`define APM_FN_CLOCK_OUT_12MHZ        4'h8
`define APM_FN_CLOCK_OUT_6MHZ         4'h9
`define APM_FN_GPIO         4'ha
`define APM_FN_WR_STROBE    4'hb
`define APM_FN_RD_STROBE    4'hc

// Factory defaults: pin4 suspend, pin3 power, pin2 rs485, pin1 rx led, pin0 tx led
`define APM_FUNC_SEL_RST    20'h51032
`define APM_CTRL_RST        1'h0
`define APM_GPIO_OUT_RST    4'h0
`define APM_GPIO_OE_RST     4'h0

// Field positions
`define APM_CTRL_PULLDOWN   0
`define APM_ST_CONFIGURED   16
`define APM_ST_SUSPEND      17
`define APM_ST_RS485        18

// Timing: activity LED pulse length at 250 MHz
`define APM_CLK_PERIOD_NS   4
`define APM_LED_PULSE_NS    100000
// 100 us of 4 ns cycles, sized to the stretch counter so it loads without truncation
`define APM_LED_PULSE_CYC   16'h61a8
`define APM_LED_CNT_W       16

`endif

// ==== verilog/apm_led_stretch.v ====
// Activity pulse stretcher that drives one active-low LED level
`timescale 1ns/1ps
`default_nettype none
`include "apm_consts.vh"

module apm_led_stretch #(
   parameter [`APM_LED_CNT_W-1:0] PULSE_CYC = `APM_LED_PULSE_CYC
) (
   // Clock and reset
   input  wire                      clk_i,
   input  wire                      nrst_i,
   // Activity event, one cycle or longer
   input  wire                      act_i,
   // LED drive, low while stretching
   output wire                      led_n_o
);

   reg [`APM_LED_CNT_W-1:0] cnt_reg;   // Remaining low time
   reg [`APM_LED_CNT_W-1:0] cnt_next;  // Next remaining low time
   reg                      led_n_reg; // Registered LED level

   // New activity reloads the count, so a burst keeps the LED lit
   always @* begin
      cnt_next = cnt_reg;
      if (act_i) begin
         cnt_next = PULSE_CYC;
      end else if (cnt_reg != {`APM_LED_CNT_W{1'b0}}) begin
         cnt_next = cnt_reg - {{(`APM_LED_CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // Counter and LED flop; LED is off after reset
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_reg   <= {`APM_LED_CNT_W{1'b0}};
         led_n_reg <= 1'b1;
      end else begin
         cnt_reg   <= cnt_next;
         led_n_reg <= (cnt_next == {`APM_LED_CNT_W{1'b0}});
      end
   end

   assign led_n_o = led_n_reg;

endmodule // apm_led_stretch
`default_nettype wire

// ==== tb/apm_aux_pin_mux_sva.sv ====
// Concurrent checks on the auxiliary pin multiplexer ports
`timescale 1ns/1ps
`default_nettype none
`include "apm_consts.vh"
module apm_aux_pin_mux_sva #(
   parameter [`APM_LED_CNT_W-1:0] LED_PULSE_CYC = `APM_LED_PULSE_CYC
) (
   // Clock, reset and APB
   input wire logic                   clk_i,
   input wire logic                   nrst_i,
   input wire logic                   psel_i,
   input wire logic                   penable_i,
   input wire logic                   pwrite_i,
   input wire logic [`APM_ADDR_W-1:0] paddr_i,
   input wire logic [31:0]            pwdata_i,
   input wire logic                   pready_o,
   input wire logic                   pslverr_o,
   // Pin sources
   input wire logic                   usb_suspend_i,
   input wire logic                   usb_configured_i,
   input wire logic                   usb_tx_act_i,
   input wire logic                   usb_rx_act_i,
   input wire logic                   uart_tx_start_i,
   input wire logic                   uart_tx_done_i,
   input wire logic                   clock_out_48mhz_i,
   input wire logic                   pin_write_strobe_n_i,
   // Pins
   input wire logic [`APM_NPINS-1:0]  aux_pin_o,
   input wire logic [`APM_NPINS-1:0]  aux_pin_oe_o,
   input wire logic                   aux_pulldown_o
);
   logic [19:0] fs_reg;              // Shadow of the selector, full-word writes only
   wire  [3:0]  f0 = fs_reg[3:0];    // Live function of pin 0
   wire  [3:0]  f2 = fs_reg[11:8];   // Live function of pin 2, where UART framing is exercised
   wire  [3:0]  f4 = fs_reg[19:16];  // Live function of pin 4
   // Follow selector writes so the pin checks know each pin's function
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) fs_reg <= `APM_FUNC_SEL_RST;
      else if (psel_i && penable_i && pwrite_i && paddr_i == `APM_OFS_FUNC_SEL) fs_reg <= pwdata_i[19:0];
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   zero_wait_a: assert property (psel_i && penable_i |-> pready_o)
      else $error("access phase without ready");
   unmapped_err_a: assert property (psel_i && penable_i && paddr_i > `APM_OFS_STATUS |-> pslverr_o)
      else $error("unmapped access without slave error");
   pulldown_gate_a: assert property (!usb_suspend_i |-> !aux_pulldown_o)
      else $error("pull-down outside suspend");
   rs485_start_a: assert property (f2 == `APM_FN_RS485 && uart_tx_start_i |-> ##2 aux_pin_o[2])
      else $error("rs485 enable missing after start");
   rs485_stop_a: assert property (f2 == `APM_FN_RS485 && uart_tx_done_i && !uart_tx_start_i ##1 !uart_tx_start_i
      |-> ##1 !aux_pin_o[2]) else $error("rs485 enable held after stop");
   power_en_a: assert property (f0 == `APM_FN_PWR_EN |=>
      aux_pin_o[0] == !($past(usb_configured_i) && !$past(usb_suspend_i))) else $error("power enable level");
   suspend_ind_a: assert property (f0 == `APM_FN_SUSPEND |=> aux_pin_o[0] == !$past(usb_suspend_i))
      else $error("suspend indicator level");
   tx_led_a: assert property (f0 == `APM_FN_TX_LED && usb_tx_act_i |-> ##2 !aux_pin_o[0] [*6])
      else $error("transmit LED not lit");
   any_led_a: assert property (f0 == `APM_FN_ANY_LED && (usb_tx_act_i || usb_rx_act_i) |-> ##2 !aux_pin_o[0])
      else $error("combined LED not lit");
   clock_out_a: assert property (f0 == `APM_FN_CLOCK_OUT_48MHZ |=> aux_pin_o[0] == $past(clock_out_48mhz_i))
      else $error("clock output not following source");
   wr_strobe_a: assert property (f0 == `APM_FN_WR_STROBE |=> aux_pin_o[0] == $past(pin_write_strobe_n_i))
      else $error("write strobe not following source");
   pin4_limit_a: assert property (f4 inside {`APM_FN_GPIO, `APM_FN_WR_STROBE, `APM_FN_RD_STROBE} |=> !aux_pin_oe_o[4])
      else $error("pin 4 driven by a low-pin-only function");
endmodule // apm_aux_pin_mux_sva
bind apm_aux_pin_mux apm_aux_pin_mux_sva #(.LED_PULSE_CYC(LED_PULSE_CYC)) apm_aux_pin_mux_sva_i (
   .clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o,
   .usb_suspend_i, .usb_configured_i, .usb_tx_act_i, .usb_rx_act_i, .uart_tx_start_i, .uart_tx_done_i,
   .clock_out_48mhz_i, .pin_write_strobe_n_i, .aux_pin_o, .aux_pin_oe_o, .aux_pulldown_o);
`default_nettype wire

// ==== tb/apm_board_model.sv ====
// Board side of the auxiliary pins: pull-ups, weak pull-down and wire levels
`timescale 1ns/1ps
`default_nettype none
`include "apm_consts.vh"
module apm_board_model (
   // Device drive
   input  wire logic [`APM_NPINS-1:0] pin_lvl_i,   // Levels the device drives
   input  wire logic [`APM_NPINS-1:0] pin_oe_i,    // High while the device drives
   input  wire logic                  pull_dn_i,   // Weak pull-down request
   // Wire levels back to the device
   output logic      [`APM_NPINS-1:0] pin_wire_o
);
   // A released pin rises through its board pull-up; the weak pull-down beats the
   // pull-up only, never a driver
   always_comb begin
      for (int i = 0; i < `APM_NPINS; i++) begin
         pin_wire_o[i] = pin_oe_i[i] ? pin_lvl_i[i] : !pull_dn_i;
      end
   end
endmodule // apm_board_model
`default_nettype wire

// ==== tb/apm_aux_pin_mux_tb_top.sv ====
// Testbench for the auxiliary pin multiplexer: APB tasks and pin scenarios
`timescale 1ns/1ps
`default_nettype none
`include "apm_consts.vh"
module apm_aux_pin_mux_tb_top;
   // Design inputs, valued at time zero
   logic        clk_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [3:0]  pstrb_i = 4'hf;  // Whole words only
   logic        usb_configured_i = 0, usb_suspend_i = 0, usb_tx_act_i = 0, usb_rx_act_i = 0;
   logic        uart_tx_start_i = 0, uart_tx_done_i = 0;
   logic        clock_out_48mhz_i = 1, clock_out_24mhz_i = 0, clock_out_12mhz_i = 1, clock_out_6mhz_i = 0;
   logic        pin_write_strobe_n_i = 0, pin_read_strobe_n_i = 1;
   // Design outputs and wire levels
   wire  [31:0] prdata_o;
   wire         pready_o, pslverr_o, aux_pulldown_o;
   wire  [4:0]  aux_pin_i, aux_pin_o, aux_pin_oe_o;
   // Bookkeeping
   int          mismatches = 0, n_checks = 0, cyc = 0;
   logic [31:0] q;  // Last read data
   logic        e;  // Last slave error
   initial forever #2 clk_i = ~clk_i;
   apm_aux_pin_mux #(.LED_PULSE_CYC(16'h0008)) apm_aux_pin_mux_i (
      .clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
      .pslverr_o, .usb_configured_i, .usb_suspend_i, .usb_tx_act_i, .usb_rx_act_i, .uart_tx_start_i,
      .uart_tx_done_i, .clock_out_48mhz_i, .clock_out_24mhz_i, .clock_out_12mhz_i, .clock_out_6mhz_i,
      .pin_write_strobe_n_i, .pin_read_strobe_n_i, .aux_pin_i, .aux_pin_o, .aux_pin_oe_o, .aux_pulldown_o);
   apm_board_model apm_board_model_i (
      .pin_lvl_i(aux_pin_o), .pin_oe_i(aux_pin_oe_o), .pull_dn_i(aux_pulldown_o), .pin_wire_o(aux_pin_i));
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One APB transfer; the request stands until ready is sampled high
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1;
      penable_i <= 0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1;
      @(posedge clk_i);
      while (pready_o !== 1'b1) @(posedge clk_i);
      q = prdata_o;
      e = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
      xfer(0, a, 32'h0);
      chk(nm, exp, q);
   endtask
   // One-cycle USB activity, then pins 1..0 while lit and after the stretch
   task automatic act(input logic t, input logic r, input logic [1:0] lit);
      usb_tx_act_i <= t;
      usb_rx_act_i <= r;
      step(1);
      usb_tx_act_i <= 0;
      usb_rx_act_i <= 0;
      step(2);
      chk("led_lit", 32'(lit), 32'(aux_pin_o[1:0]));
      step(12);
      chk("led_dark", 32'h3, 32'(aux_pin_o[1:0]));
   endtask
   // One-cycle framing pulses, then the RS485 enable on pin 2
   task automatic uart(input logic s, input logic d, input logic exp);
      uart_tx_start_i <= s;
      uart_tx_done_i <= d;
      step(1);
      uart_tx_start_i <= 0;
      uart_tx_done_i <= 0;
      step(2);
      chk("rs485_pin", 32'(exp), 32'(aux_pin_o[2]));
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Hang guard, far above the roughly 210 cycles the run needs
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         mismatches++;
         print_verdict();
      end
   end
   initial begin
      logic [12:0] tbl;
      tbl = 13'h157c;  // Pin 0 level per code under the held sources
      step(6);
      nrst_i <= 1;
      step(2);
      chk("pins_rst", 32'h1b, 32'(aux_pin_o));
      chk("oe_rst", 32'h1f, 32'(aux_pin_oe_o));
      rd(`APM_OFS_FUNC_SEL, 32'h51032, "func_sel");
      rd(`APM_OFS_CTRL, 32'h0, "ctrl");
      rd(`APM_OFS_GPIO, 32'h0, "gpio");
      act(1, 0, 2'b10);
      act(0, 1, 2'b01);
      xfer(1, `APM_OFS_FUNC_SEL, 32'h51034);
      act(0, 1, 2'b00);
      act(1, 0, 2'b10);
      uart(1, 0, 1);
      uart(0, 0, 1);
      uart(0, 1, 0);
      uart(1, 1, 1);
      uart(0, 1, 0);
      usb_configured_i <= 1;
      step(3);
      chk("pwr_on", 32'h2, 32'(aux_pin_o[4:3]));
      xfer(1, `APM_OFS_FUNC_SEL, 32'h5103d);
      usb_suspend_i <= 1;
      step(3);
      chk("suspended", 32'h1, 32'(aux_pin_o[4:3]));
      chk("pd_off", 32'h0, 32'(aux_pulldown_o));
      xfer(1, `APM_OFS_CTRL, 32'h1);
      step(1);
      chk("pd_on", 32'h1, 32'(aux_pulldown_o));
      rd(`APM_OFS_STATUS, 32'h00030b0a, "status_pd");
      usb_suspend_i <= 0;
      step(3);
      chk("pd_resume", 32'h0, 32'(aux_pulldown_o));
      rd(`APM_OFS_STATUS, 32'h00011313, "status_up");
      xfer(1, `APM_OFS_GPIO, 32'h11);
      for (int c = 0; c < 13; c++) begin
         xfer(1, `APM_OFS_FUNC_SEL, {12'h0, 16'h5103, 4'(c)});
         step(2);
         chk("pin0_fn", 32'(tbl[c]), 32'(aux_pin_o[0]));
         chk("pin0_oe", 32'h1, 32'(aux_pin_oe_o[0]));
      end
      for (int c = 10; c < 13; c++) begin
         xfer(1, `APM_OFS_FUNC_SEL, {12'h0, 4'(c), 16'h1032});
         step(2);
         chk("pin4_oe", 32'h0, 32'(aux_pin_oe_o[4]));
      end
      // GPIO level set but its enable cleared: the pin must stay released
      xfer(1, `APM_OFS_FUNC_SEL, 32'h5103a);
      xfer(1, `APM_OFS_GPIO, 32'h01);
      step(2);
      chk("gpio_oe_off", 32'h0, 32'(aux_pin_oe_o[0]));
      xfer(0, 12'h010, 32'h0);
      chk("unmapped_err", 32'h1, 32'(e));
      chk("unmapped_data", 32'h0, q);
      print_verdict();
   end
endmodule // apm_aux_pin_mux_tb_top
`default_nettype wire
